//--- rtl/nvsc_pkg.sv
// Operation
// - Host holds address through whole write
// - Host keeps output enable high writing
// - Six reads ending 0F0F start store
// - Six reads ending 0F0E start recall
// - Sequence reads ended by chip enable rising
// - Write enable high through whole sequence
// - Host avoids write state at power-up
package nvsc_pkg;

    // ----------------------------------------
    // Memory geometry
    // ----------------------------------------
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int CNT_W  = 18;

    // ----------------------------------------
    // Software sequence addresses
    // ----------------------------------------
    localparam logic [12:0] SEQ_A0      = 13'h0000;
    localparam logic [12:0] SEQ_A1      = 13'h1555;
    localparam logic [12:0] SEQ_A2      = 13'h0AAA;
    localparam logic [12:0] SEQ_A3      = 13'h1FFF;
    localparam logic [12:0] SEQ_A4      = 13'h10F0;
    localparam logic [12:0] SEQ_STORE   = 13'h0F0F;
    localparam logic [12:0] SEQ_RECALL  = 13'h0F0E;
    localparam logic [2:0]  SEQ_LAST    = 3'h5;

    // ----------------------------------------
    // Timing, clock 20 MHz
    // ----------------------------------------
    localparam int CLK_NS          = 50;
    localparam int ACCESS_NS       = 55;   // Slowest grade access and pulse
    localparam int PULL_PULSE_NS   = 15;
    localparam int STORE_MS        = 10;   // store_duration
    localparam int RECALL_US       = 20;   // recall_duration
    localparam int RESTORE_US      = 550;  // powerup_recall_time
    localparam int DELAY_US        = 1;    // cycle_completion_window
    localparam int ACCESS_CYC      = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULL_PULSE_CYC  = (PULL_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int STORE_CYC_DEF   = (STORE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int RECALL_CYC      = (RECALL_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int RESTORE_CYC_DEF = (RESTORE_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int DELAY_CYC       = (DELAY_US * 1000 + CLK_NS - 1) / CLK_NS;

    // ----------------------------------------
    // Host commands and states
    // ----------------------------------------
    typedef enum logic [2:0] {
        NVSC_CMD_READ,
        NVSC_CMD_WRITE,
        NVSC_CMD_SW_STORE,
        NVSC_CMD_SW_RECALL,
        NVSC_CMD_HW_STORE
    } nvsc_cmd_t;

    typedef enum logic [2:0] {
        NVSC_ST_POWERUP,
        NVSC_ST_IDLE,
        NVSC_ST_SETUP,
        NVSC_ST_ACT,
        NVSC_ST_END,
        NVSC_ST_NVWAIT,
        NVSC_ST_PULL_LOW,
        NVSC_ST_PULL_WAIT
    } nvsc_state_t;

endpackage

//--- rtl/nvsc_host.sv
`timescale 1ns/100ps
module nvsc_host #(
    parameter int STORE_CYC   = nvsc_pkg::STORE_CYC_DEF,   // Store wait
    parameter int RESTORE_CYC = nvsc_pkg::RESTORE_CYC_DEF  // Power-up recall wait
) (
    input  wire logic                        i_clk,            // 20 MHz clock
    input  wire logic                        i_rstn,           // Async reset, low
    input  wire logic                        i_req,            // Command request
    input  wire nvsc_pkg::nvsc_cmd_t         i_cmd,            // Command code
    input  wire logic [nvsc_pkg::ADDR_W-1:0] i_addr,           // Access address
    input  wire logic [nvsc_pkg::DATA_W-1:0] i_wdata,          // Write data
    output logic                             o_ready,          // Accepts request
    output logic                             o_done,           // Command finished
    output logic [nvsc_pkg::DATA_W-1:0]      o_rdata,          // Read data
    output logic [nvsc_pkg::ADDR_W-1:0]      o_address_bus,    // Address pins
    output logic                             o_ce_n,           // Chip enable
    output logic                             o_oe_n,           // Output enable
    output logic                             o_we_n,           // Write enable
    input  wire logic [nvsc_pkg::DATA_W-1:0] i_data_lines,     // Data pins in
    output logic [nvsc_pkg::DATA_W-1:0]      o_data_lines,     // Data pins out
    output logic                             o_data_lines_oe,  // Data pins drive
    input  wire logic                        i_hw_store_busy_n,// Strobe pin in
    output logic                             o_hw_store_busy_n,// Strobe pin out
    output logic                             o_hw_store_busy_oe // Strobe pull low
);
    import nvsc_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        nvsc_state_t         state;
        nvsc_cmd_t           cmd;
        logic [CNT_W-1:0]    cnt;
        logic [2:0]          step;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [DATA_W-1:0]   rdata;
        logic                ready;
        logic                done;
        logic                ce_n;
        logic                oe_n;
        logic                we_n;
        logic                data_oe;
        logic                pull_oe;
    } nvsc_regs_t;

    nvsc_regs_t r_reg;
    nvsc_regs_t r_next;

    // Address of one step of the store or recall sequence
    function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] step, input logic recall);
        logic [ADDR_W-1:0] a;
        a = SEQ_A0;
        case (step)
            3'h0: a = SEQ_A0;
            3'h1: a = SEQ_A1;
            3'h2: a = SEQ_A2;
            3'h3: a = SEQ_A3;
            3'h4: a = SEQ_A4;
            default: a = recall ? SEQ_RECALL : SEQ_STORE;
        endcase
        return a;
    endfunction

    function automatic logic is_seq(input nvsc_cmd_t c);
        return (c == NVSC_CMD_SW_STORE) || (c == NVSC_CMD_SW_RECALL);
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        r_next      = r_reg;
        r_next.done = 1'b0;
        case (r_reg.state)
            NVSC_ST_POWERUP:
            begin
                r_next.ce_n = 1'b1;
                r_next.we_n = 1'b1;
                if (r_reg.cnt == '0)
                begin
                    r_next.state = NVSC_ST_IDLE;
                    r_next.ready = i_hw_store_busy_n;
                end
                else
                begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            NVSC_ST_IDLE:
            begin
                r_next.ready = i_hw_store_busy_n;
                if (i_req && r_reg.ready)
                begin
                    r_next.ready = 1'b0;
                    r_next.cmd   = i_cmd;
                    r_next.wdata = i_wdata;
                    r_next.step  = 3'h0;
                    if (i_cmd == NVSC_CMD_HW_STORE)
                    begin
                        r_next.state   = NVSC_ST_PULL_LOW;
                        r_next.pull_oe = 1'b1;
                        r_next.cnt     = CNT_W'(PULL_PULSE_CYC - 1);
                    end
                    else
                    begin
                        r_next.state = NVSC_ST_SETUP;
                        r_next.addr  = is_seq(i_cmd) ? seq_addr(3'h0, i_cmd == NVSC_CMD_SW_RECALL) : i_addr;
                    end
                end
            end
            // Address settles with both strobes high
            NVSC_ST_SETUP:
            begin
                r_next.state = NVSC_ST_ACT;
                r_next.ce_n  = 1'b0;
                r_next.cnt   = CNT_W'(ACCESS_CYC - 1);
                if (r_reg.cmd == NVSC_CMD_WRITE)
                begin
                    r_next.we_n    = 1'b0;
                    r_next.data_oe = 1'b1;
                end
                else
                begin
                    // sequence reads leave OE and WE high
                    r_next.oe_n = is_seq(r_reg.cmd);
                end
            end
            NVSC_ST_ACT:
            begin
                if (r_reg.cnt == '0)
                begin
                    // chip enable rising ends each access
                    r_next.state = NVSC_ST_END;
                    r_next.ce_n  = 1'b1;
                    r_next.we_n  = 1'b1;
                    r_next.oe_n  = 1'b1;
                    if (r_reg.cmd == NVSC_CMD_READ)
                    begin
                        r_next.rdata = i_data_lines;
                    end
                end
                else
                begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            // address and data held one cycle past strobes
            NVSC_ST_END:
            begin
                r_next.data_oe = 1'b0;
                if (is_seq(r_reg.cmd) && (r_reg.step != SEQ_LAST))
                begin
                    // sequence steps follow back to back
                    r_next.step  = r_reg.step + 3'h1;
                    r_next.addr  = seq_addr(r_reg.step + 3'h1, r_reg.cmd == NVSC_CMD_SW_RECALL);
                    r_next.state = NVSC_ST_SETUP;
                end
                else if (is_seq(r_reg.cmd))
                begin
                    r_next.state = NVSC_ST_NVWAIT;
                    r_next.cnt   = (r_reg.cmd == NVSC_CMD_SW_RECALL) ? CNT_W'(RECALL_CYC - 1)
                                                                     : CNT_W'(STORE_CYC - 1);
                end
                else
                begin
                    r_next.state = NVSC_ST_IDLE;
                    r_next.done  = 1'b1;
                end
            end
            NVSC_ST_NVWAIT:
            begin
                if (r_reg.cnt == '0)
                begin
                    r_next.state = NVSC_ST_IDLE;
                    r_next.done  = 1'b1;
                end
                else
                begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            // request store by pulling strobe low
            NVSC_ST_PULL_LOW:
            begin
                if (r_reg.cnt == '0)
                begin
                    r_next.pull_oe = 1'b0;
                    r_next.state   = NVSC_ST_PULL_WAIT;
                    r_next.cnt    = CNT_W'(DELAY_CYC);
                end
                else
                begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            // wait window, then for strobe release
            NVSC_ST_PULL_WAIT:
            begin
                if (r_reg.cnt != '0)
                begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
                else if (i_hw_store_busy_n)
                begin
                    r_next.state = NVSC_ST_IDLE;
                    r_next.done  = 1'b1;
                end
            end
            default:
            begin
                r_next.state = NVSC_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            r_reg         <= '0;
            r_reg.state   <= NVSC_ST_POWERUP;
            r_reg.cnt     <= CNT_W'(RESTORE_CYC - 1);
            r_reg.cmd     <= NVSC_CMD_READ;
            r_reg.ce_n    <= 1'b1;
            r_reg.oe_n    <= 1'b1;
            r_reg.we_n    <= 1'b1;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // Outputs straight from flops, strobe out tied low
    assign o_ready            = r_reg.ready;
    assign o_done             = r_reg.done;
    assign o_rdata            = r_reg.rdata;
    assign o_address_bus      = r_reg.addr;
    assign o_ce_n             = r_reg.ce_n;
    assign o_oe_n             = r_reg.oe_n;
    assign o_we_n             = r_reg.we_n;
    assign o_data_lines       = r_reg.wdata;
    assign o_data_lines_oe    = r_reg.data_oe;
    assign o_hw_store_busy_n  = 1'b0;
    assign o_hw_store_busy_oe = r_reg.pull_oe;

endmodule // nvsc_host

//--- tb/nvsc_host_checker.sv
`timescale 1ns/100ps
module nvsc_host_checker #(
    parameter int STORE_CYC   = 50, // Store wait
    parameter int RESTORE_CYC = 10  // Power-up wait
) (
    input wire logic                        i_clk,              // Clock
    input wire logic                        i_rstn,             // Reset
    input wire logic                        i_req,              // Request
    input wire nvsc_pkg::nvsc_cmd_t         i_cmd,              // Command
    input wire logic [nvsc_pkg::ADDR_W-1:0] i_addr,             // Address
    input wire logic [nvsc_pkg::DATA_W-1:0] i_wdata,            // Write data
    input wire logic                        o_ready,            // Ready
    input wire logic                        o_done,             // Done
    input wire logic [nvsc_pkg::DATA_W-1:0] o_rdata,            // Read data
    input wire logic [nvsc_pkg::ADDR_W-1:0] o_address_bus,      // Address pins
    input wire logic                        o_ce_n,             // Chip enable
    input wire logic                        o_oe_n,             // Output enable
    input wire logic                        o_we_n,             // Write enable
    input wire logic [nvsc_pkg::DATA_W-1:0] i_data_lines,       // Data in
    input wire logic [nvsc_pkg::DATA_W-1:0] o_data_lines,       // Data out
    input wire logic                        o_data_lines_oe,    // Data drive
    input wire logic                        i_hw_store_busy_n,  // Strobe level
    input wire logic                        o_hw_store_busy_n,  // Strobe out
    input wire logic                        o_hw_store_busy_oe  // Strobe pull
);
    import nvsc_pkg::*;
    logic take;

    // ----------------------------------------
    // Port timing checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);
    // Request taken this edge
    assign take = i_req && o_ready;
    ready_drop_a: assert property (take |=> !o_ready) else $error("ready stayed high after take");
    done_pulse_a: assert property (o_done |=> !o_done) else $error("done longer than a cycle");
    read_strobe_a: assert property (take && i_cmd == NVSC_CMD_READ |-> ##2 (!o_ce_n && !o_oe_n && o_we_n))
        else $error("read strobes wrong");
    read_done_a: assert property (take && i_cmd == NVSC_CMD_READ |-> ##5 o_done) else $error("read late");
    write_strobe_a: assert property (take && i_cmd == NVSC_CMD_WRITE |-> ##2
        (!o_ce_n && !o_we_n && o_oe_n && o_data_lines_oe)) else $error("write strobes wrong");
    addr_hold_a: assert property (!o_ce_n && !o_we_n |=> $stable(o_address_bus)) else $error("address moved");
    data_hold_a: assert property (o_data_lines_oe && !o_we_n |=> o_data_lines_oe && $stable(o_data_lines))
        else $error("write data moved");
    no_contend_a: assert property (o_data_lines_oe |-> o_oe_n) else $error("output enable low while driving");
    seq_reads_a: assert property (take && (i_cmd == NVSC_CMD_SW_STORE || i_cmd == NVSC_CMD_SW_RECALL)
        |=> (o_we_n && o_oe_n) [*8]) else $error("sequence not plain reads");
    hsb_pulse_a: assert property (take && i_cmd == NVSC_CMD_HW_STORE |=> o_hw_store_busy_oe ##1
        !o_hw_store_busy_oe) else $error("strobe pulse wrong");
    hsb_block_a: assert property (!i_hw_store_busy_n |=> !o_ready) else $error("ready while strobe low");
endmodule // nvsc_host_checker

bind nvsc_host nvsc_host_checker #(.STORE_CYC(STORE_CYC), .RESTORE_CYC(RESTORE_CYC)) chk_u (.*);

//--- tb/nvsc_dev_model.sv
`timescale 1ns/100ps
module nvsc_dev_model
    import nvsc_pkg::*;
#(
    parameter int STORE_NS  = 5000, // Scaled store time
    parameter int RECALL_NS = 15000 // Recall time
) (
    input  wire logic [12:0] i_addr,  // Address pins
    input  wire logic        i_ce_n,  // Chip enable
    input  wire logic        i_oe_n,  // Output enable
    input  wire logic        i_we_n,  // Write enable
    input  wire logic [7:0]  i_dq,    // Data lines in
    input  wire logic        i_busy_n, // Strobe level
    output logic [7:0]       o_q,      // Data lines out
    output logic             o_q_oe,   // Data drive
    output logic             o_busy_oe // Strobe pull
);
    logic [7:0]  mem [8192];
    logic [7:0]  nv [8192];
    logic [12:0] seq [5] = '{SEQ_A0, SEQ_A1, SEQ_A2, SEQ_A3, SEQ_A4};
    logic        busy = 0, dirty = 0, wrote = 0, wr_act;
    int          step = 0;

    // ----------------------------------------
    // Memory array
    // ----------------------------------------
    // read drive
    assign o_q_oe = !i_ce_n && !i_oe_n && i_we_n && i_busy_n && !busy;
    assign o_q    = mem[i_addr];
    assign wr_act = !i_ce_n && !i_we_n && i_busy_n && !busy;
    initial
    begin
        nv        = '{default: 8'h00};
        mem       = nv;
        o_busy_oe = 0;
    end
    // Latch data at write end
    always @(negedge wr_act)
        if (!busy && i_busy_n)
        begin
            mem[i_addr] = i_dq;
            dirty       = 1;
        end
    always @(posedge wr_act) wrote = 1;

    // ----------------------------------------
    // Nonvolatile cycles
    // ----------------------------------------
    // erase then program
    task automatic run_store(input int pre);
        busy      = 1;
        o_busy_oe = 1;
        #(pre);
        nv = '{default: 8'hFF};
        #(STORE_NS);
        nv        = mem;
        dirty     = 0;
        o_busy_oe = 0;
        busy      = 0;
    endtask
    task automatic run_recall;
        busy = 1;
        mem  = '{default: 8'h00};
        #(RECALL_NS);
        mem   = nv;
        dirty = 0;
        busy  = 0;
    endtask
    always @(posedge i_ce_n)
    begin
        if (wrote || busy || !i_we_n) step = 0;
        else if (step == 5 && i_addr == SEQ_STORE) run_store(0);
        else if (step == 5 && i_addr == SEQ_RECALL) run_recall();
        else if (step < 5 && i_addr == seq[step]) step++;
        else step = (i_addr == SEQ_A0) ? 1 : 0;
        if (step == 5 && !busy && i_addr != SEQ_A4) step = 0;
        wrote = 0;
    end
    // supply drop: strobe low 1 us, held on if a store or recall is busy
    task automatic supply_drop;
        o_busy_oe = 1;
        #1000;
        if (!busy) o_busy_oe = 0;
    endtask
    always @(negedge i_busy_n)
        if (!busy && dirty) run_store(1000);
endmodule // nvsc_dev_model

//--- tb/nvsc_host_tb_top.sv
`timescale 1ns/100ps
module nvsc_host_tb_top;
    import nvsc_pkg::*;
    logic        i_clk = 0, i_rstn = 0, i_req = 0;
    nvsc_cmd_t   i_cmd = NVSC_CMD_READ;
    logic [12:0] i_addr = 0, o_address_bus;
    logic [7:0]  i_wdata = 0, o_rdata, o_data_lines, dq, dev_q;
    logic        o_ready, o_done, o_ce_n, o_oe_n, o_we_n, o_data_lines_oe, o_hw_store_busy_oe, dev_q_oe;
    logic        dev_busy_oe, busy_n, host_busy_n;
    int          err_total = 0, num_checks = 0, n;

    // ----------------------------------------
    // Pins, clock and instances
    // ----------------------------------------
    // Shared data lines, pulled-up strobe
    assign dq    = o_data_lines_oe ? o_data_lines : (dev_q_oe ? dev_q : ~dev_q);
    assign busy_n = (o_hw_store_busy_oe ? host_busy_n : 1'b1) && !dev_busy_oe;
    initial forever #25 i_clk = ~i_clk;
    nvsc_host #(.STORE_CYC(200), .RESTORE_CYC(10)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req),
        .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata), .o_ready(o_ready), .o_done(o_done), .o_rdata(o_rdata),
        .o_address_bus(o_address_bus), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n), .o_we_n(o_we_n), .i_data_lines(dq),
        .o_data_lines(o_data_lines), .o_data_lines_oe(o_data_lines_oe), .i_hw_store_busy_n(busy_n),
        .o_hw_store_busy_n(host_busy_n), .o_hw_store_busy_oe(o_hw_store_busy_oe));
    nvsc_dev_model dev_u (.i_addr(o_address_bus), .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n), .i_dq(dq),
        .i_busy_n(busy_n), .o_q(dev_q), .o_q_oe(dev_q_oe), .o_busy_oe(dev_busy_oe));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One command, cycles from take to done
    task automatic do_cmd(input nvsc_cmd_t c, input logic [12:0] a, input logic [7:0] d);
        n = 1;
        @(negedge i_clk);
        while (o_ready !== 1'b1) @(negedge i_clk);
        i_req   = 1;
        i_cmd   = c;
        i_addr  = a;
        i_wdata = d;
        @(negedge i_clk);
        i_req = 0;
        while (o_done !== 1'b1 && n < 20000)
        begin
            @(negedge i_clk);
            n++;
        end
    endtask
    task automatic rd_chk(input logic [12:0] a, input logic [7:0] d);
        do_cmd(NVSC_CMD_READ, a, 8'h00);
        check(o_rdata, d);
        check(n, ACCESS_CYC + 3);
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Plain writes and reads at both address ends and at 0ABC
    task automatic t_rw;
        logic [12:0] a [3] = '{13'h0000, 13'h1FFF, 13'h0ABC};
        for (int i = 0; i < 3; i++)
        begin
            do_cmd(NVSC_CMD_WRITE, a[i], 8'hA0 + 8'(i));
            check(n, ACCESS_CYC + 3);
        end
        for (int i = 0; i < 3; i++) rd_chk(a[i], 8'hA0 + 8'(i));
    endtask
    // Software store, overwrite, then recall twice
    task automatic t_sw;
        do_cmd(NVSC_CMD_WRITE, 13'h0123, 8'h5A);
        do_cmd(NVSC_CMD_SW_STORE, 13'h0000, 8'h00);
        do_cmd(NVSC_CMD_WRITE, 13'h0123, 8'hC3);
        rd_chk(13'h0123, 8'hC3);
        for (int i = 0; i < 2; i++)
        begin
            do_cmd(NVSC_CMD_SW_RECALL, 13'h0000, 8'h00);
            rd_chk(13'h0123, 8'h5A);
        end
    endtask
    // Strobe store after a write, then with nothing written
    task automatic t_hw;
        do_cmd(NVSC_CMD_WRITE, 13'h0200, 8'h77);
        do_cmd(NVSC_CMD_HW_STORE, 13'h0000, 8'h00);
        check(n >= 120, 1);
        do_cmd(NVSC_CMD_WRITE, 13'h0200, 8'h11);
        do_cmd(NVSC_CMD_SW_RECALL, 13'h0000, 8'h00);
        rd_chk(13'h0200, 8'h77);
        do_cmd(NVSC_CMD_HW_STORE, 13'h0000, 8'h00);
        check(n, PULL_PULSE_CYC + DELAY_CYC + 2);
    endtask
    // Supply drop with nothing written: pulse only, then a normal read
    task automatic t_drop;
        dev_u.supply_drop();
        check(o_ready, 1'b0);
        rd_chk(13'h0200, 8'h77);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(negedge i_clk);
        i_rstn = 1;
        t_rw();
        t_sw();
        t_hw();
        t_drop();
        stop_test();
    end
    // Watchdog
    initial
    begin
        #500000;
        err_total++;
        stop_test();
    end
endmodule // nvsc_host_tb_top
